//--- gpib_cfg.svh
// Constants shared by both ends of the instrument bus link.
// Assumes inclusion by its bare name from each design file.
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH
// Bus command codes.
`define CMD_GO_LOCAL 8'h01
`define CMD_SEL_CLEAR 8'h04
`define CMD_PP_CONFIG 8'h05
`define CMD_TRIGGER 8'h08
`define CMD_TAKE_CTL 8'h09
`define CMD_LOCKOUT 8'h11
`define CMD_DEV_CLEAR 8'h14
`define CMD_PP_UNCONFIG 8'h15
`define CMD_SPOLL_ON 8'h18
`define CMD_SPOLL_OFF 8'h19
`define CMD_UNLISTEN 8'h3F
`define CMD_UNTALK 8'h5F
`define LISTEN_BASE 8'h20
`define LISTEN_LAST 8'h3E
`define TALK_BASE 8'h40
`define TALK_LAST 8'h5E
`define SEC_BASE 8'h60
`define PP_ENABLE_LAST 8'h6F
`define PP_DISABLE 8'h70
// Controller register offsets (byte addresses), field bits and AXI response codes.
`define REG_CTRL 12'h000
`define REG_TX 12'h004
`define REG_RX 12'h008
`define CTRL_REN_BIT 0
`define CTRL_RESET 1'b1
`define TX_ATN_BIT 8
`define RX_VALID_BIT 8
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

//--- gpib_controller.sv
// Active controller end: software sends bytes and reads answers over
// AXI4-Lite registers. Assumes it is the only party driving ATN.
`include "gpib_cfg.svh"
module gpib_controller
  import gpib_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus side.
  gpib_if.controller bus
);

  // ************************************************************
  // Write path
  // ************************************************************
  wr_state_t wr_state_r;
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic rx_valid_r;
  bus_byte_t rx_byte_r;
  logic rd_clear;

  assign do_write = (wr_state_r == WR_IDLE) && aw_have_r && w_have_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end else begin
        if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
          s_axi_awready <= 1'b1;
          aw_have_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
          s_axi_wready <= 1'b1;
          w_have_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      case (wr_state_r)
        WR_IDLE: begin
          if (do_write) begin
            wr_state_r <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == `REG_CTRL || aw_addr_r == `REG_TX)
              ? `AXI_OKAY : `AXI_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_r <= WR_IDLE;
          end
        end
        default: wr_state_r <= WR_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Bus drive
  // ************************************************************
  // REN comes up enabled so devices accept commands from reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.ren_n <= ~`CTRL_RESET;
    end else if (do_write && aw_addr_r == `REG_CTRL && w_strb_r[0]) begin
      bus.ren_n <= ~w_data_r[`CTRL_REN_BIT];
    end
  end

  // ATN is a level that stays until the next byte, so a polled talker
  // can answer once software sends a data-mode byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.atn_n <= 1'b1;
      bus.ctl_dav <= 1'b0;
      bus.ctl_dio <= 8'h00;
    end else begin
      bus.ctl_dav <= 1'b0;
      if (do_write && aw_addr_r == `REG_TX && w_strb_r[0]) begin
        bus.atn_n <= ~w_data_r[`TX_ATN_BIT];
        bus.ctl_dav <= 1'b1;
        bus.ctl_dio <= w_data_r[7:0];
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // A device answer wins over a clearing read in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end else if (bus.dev_dav) begin
      rx_valid_r <= 1'b1;
      rx_byte_r <= bus.dio;
    end else if (rd_clear) begin
      rx_valid_r <= 1'b0;
    end
  end

  assign rd_clear = s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_RX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata[`CTRL_REN_BIT] <= ~bus.ren_n;
          `REG_TX: s_axi_rdata[8:0] <= {~bus.atn_n, bus.ctl_dio};
          `REG_RX: s_axi_rdata[8:0] <= {rx_valid_r, rx_byte_r};
          default: s_axi_rresp <= `AXI_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // gpib_controller

//--- gpib_device.sv
// Device end of the instrument bus: decodes command bytes and keeps the
// addressing, remote, lockout, serial poll and parallel poll state.
// Assumes one active controller drives ATN and strobes each byte with dav.
`include "gpib_cfg.svh"
module gpib_device
  import gpib_pkg::*;
#(
  parameter bit TALK_CAPABLE = 1'b1,
  parameter bit CTL_CAPABLE = 1'b0
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus side.
  gpib_if.device bus,
  // Device configuration.
  input wire logic [4:0] my_addr,
  input wire logic [7:0] status_byte,
  // Addressing and mode state.
  output logic listener,
  output logic talker,
  output logic remote,
  output logic lockout,
  output logic spoll_mode,
  // Parallel poll configuration.
  output logic pp_enabled,
  output logic pp_sense,
  output logic [2:0] pp_line,
  // Action pulses.
  output logic trigger,
  output logic dev_clear,
  output logic take_ctl,
  output logic sec_valid,
  output logic [7:0] sec_code
);

  // ************************************************************
  // Command classification
  // ************************************************************
  logic cmd_take;
  bus_byte_t cmd;
  logic is_listen;
  logic is_talk;
  logic own_listen;
  logic own_talk;
  logic is_sec;
  logic addr_ok;
  logic pp_pending_r;
  logic spoll_sent_r;

  // Bytes on the data lines are commands only with ATN low and REN on.
  assign cmd_take = bus.ctl_dav & ~bus.atn_n & ~bus.ren_n;
  assign cmd = bus.dio;
  assign is_listen = (cmd >= `LISTEN_BASE) && (cmd <= `LISTEN_LAST);
  assign is_talk = (cmd >= `TALK_BASE) && (cmd <= `TALK_LAST);
  assign own_listen = is_listen && (cmd[4:0] == my_addr);
  assign own_talk = is_talk && (cmd[4:0] == my_addr);
  assign is_sec = cmd >= `SEC_BASE;
  // Addressed commands need the listener state held before this byte.
  assign addr_ok = cmd_take & listener;

  // ************************************************************
  // Listener and talker state
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      listener <= 1'b0;
    end else if (cmd_take) begin
      if (cmd == `CMD_UNLISTEN) begin
        listener <= 1'b0;
      end else if (own_listen) begin
        listener <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      talker <= 1'b0;
    end else if (cmd_take) begin
      if (cmd == `CMD_UNTALK) begin
        talker <= 1'b0;
      end else if (own_talk) begin
        talker <= 1'b1;
      end else if (is_talk) begin
        talker <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Remote and lockout state
  // ************************************************************
  // The device starts in local control until it is first addressed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote <= 1'b0;
    end else if (cmd_take) begin
      if (own_listen || own_talk) begin
        remote <= 1'b1;
      end else if (addr_ok && cmd == `CMD_GO_LOCAL) begin
        remote <= 1'b0;
      end
    end
  end

  // Lockout is only released by reset; no bus code clears it here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lockout <= 1'b0;
    end else if (cmd_take && cmd == `CMD_LOCKOUT) begin
      lockout <= 1'b1;
    end
  end

  // ************************************************************
  // Serial poll
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spoll_mode <= 1'b0;
    end else if (cmd_take) begin
      if (cmd == `CMD_SPOLL_ON && TALK_CAPABLE) begin
        spoll_mode <= 1'b1;
      end else if (cmd == `CMD_SPOLL_OFF) begin
        spoll_mode <= 1'b0;
      end
    end
  end

  // One status byte per poll; a new command phase re-arms the answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spoll_sent_r <= 1'b0;
      bus.dev_dav <= 1'b0;
      bus.dev_dio_oe <= 1'b0;
      bus.dev_dio <= 8'h00;
    end else begin
      bus.dev_dav <= 1'b0;
      bus.dev_dio_oe <= 1'b0;
      if (!bus.atn_n) begin
        spoll_sent_r <= 1'b0;
      end else if (spoll_mode && talker && !spoll_sent_r) begin
        spoll_sent_r <= 1'b1;
        bus.dev_dav <= 1'b1;
        bus.dev_dio_oe <= 1'b1;
        bus.dev_dio <= status_byte;
      end
    end
  end

  // ************************************************************
  // Parallel poll configuration
  // ************************************************************
  // The pending flag lives for exactly one following command byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_pending_r <= 1'b0;
    end else if (cmd_take) begin
      pp_pending_r <= addr_ok && cmd == `CMD_PP_CONFIG;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_enabled <= 1'b0;
      pp_sense <= 1'b0;
      pp_line <= 3'd0;
    end else if (cmd_take) begin
      if (cmd == `CMD_PP_UNCONFIG) begin
        pp_enabled <= 1'b0;
        pp_sense <= 1'b0;
        pp_line <= 3'd0;
      end else if (pp_pending_r && is_sec && cmd <= `PP_ENABLE_LAST) begin
        pp_enabled <= 1'b1;
        pp_sense <= cmd[3];
        pp_line <= cmd[2:0];
      end else if (pp_pending_r && cmd == `PP_DISABLE) begin
        pp_enabled <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Action pulses
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger <= 1'b0;
      dev_clear <= 1'b0;
      take_ctl <= 1'b0;
    end else begin
      trigger <= addr_ok && cmd == `CMD_TRIGGER;
      dev_clear <= (cmd_take && cmd == `CMD_DEV_CLEAR)
        || (addr_ok && cmd == `CMD_SEL_CLEAR);
      take_ctl <= CTL_CAPABLE && cmd_take && talker && cmd == `CMD_TAKE_CTL;
    end
  end

  // Secondaries outside a configure sequence are handed to the user.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_valid <= 1'b0;
      sec_code <= 8'h00;
    end else begin
      sec_valid <= cmd_take && is_sec && !pp_pending_r;
      if (cmd_take && is_sec && !pp_pending_r) begin
        sec_code <= cmd;
      end
    end
  end

endmodule // gpib_device

//--- gpib_if.sv
// Instrument bus wiring between the active controller and one device.
// Assumes both parties share aclk; the data lines are resolved here.
interface gpib_if;
  import gpib_pkg::*;
  // Controller drive.
  bus_byte_t ctl_dio;
  logic atn_n;
  logic ren_n;
  logic ctl_dav;
  // Device drive.
  bus_byte_t dev_dio;
  logic dev_dio_oe;
  logic dev_dav;
  // Resolved data lines.
  bus_byte_t dio;
  assign dio = dev_dio_oe ? dev_dio : ctl_dio;
  modport controller (
    output ctl_dio, atn_n, ren_n, ctl_dav,
    input dio, dev_dav
  );
  modport device (
    output dev_dio, dev_dio_oe, dev_dav,
    input dio, atn_n, ren_n, ctl_dav
  );
endinterface

//--- gpib_link_sva.sv
// Concurrent checks on the instrument bus link and the device's outputs.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
module gpib_link_sva
  import gpib_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Link lines.
  input wire bus_byte_t ctl_dio,
  input wire logic atn_n,
  input wire logic ren_n,
  input wire logic ctl_dav,
  input wire bus_byte_t dev_dio,
  input wire logic dev_dio_oe,
  input wire logic dev_dav,
  // Device state.
  input wire logic [4:0] my_addr,
  input wire logic [7:0] status_byte,
  input wire logic listener,
  input wire logic talker,
  input wire logic remote,
  input wire logic lockout,
  input wire logic spoll_mode,
  input wire logic pp_enabled,
  input wire logic trigger,
  input wire logic dev_clear,
  input wire logic take_ctl
);
  // ****************
  // Properties
  // ****************
  logic cmd;
  assign cmd = ctl_dav && !atn_n && !ren_n;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_listen;
    cmd && ctl_dio == {3'b001, my_addr} && my_addr != 5'h1f |=> listener && remote;
  endproperty
  a_listen: assert property (p_listen) else $error("own listen address missed");
  property p_talk;
    cmd && ctl_dio == {3'b010, my_addr} && my_addr != 5'h1f |=> talker && remote;
  endproperty
  a_talk: assert property (p_talk) else $error("own talk address missed");
  property p_unl;
    cmd && ctl_dio == 8'h3f |=> !listener;
  endproperty
  a_unl: assert property (p_unl) else $error("listener kept after unlisten");
  property p_fgn;
    cmd && ctl_dio[7:5] == 3'b010 && ctl_dio[4:0] != my_addr |=> !talker;
  endproperty
  a_fgn: assert property (p_fgn) else $error("talker kept");
  property p_trig;
    trigger == $past(cmd && ctl_dio == 8'h08 && listener);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse wrong");
  property p_clr;
    dev_clear == $past(cmd && (ctl_dio == 8'h14 || ctl_dio == 8'h04 && listener));
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse wrong");
  property p_local;
    cmd && ctl_dio == 8'h01 && listener |=> !remote;
  endproperty
  a_local: assert property (p_local) else $error("remote kept");
  property p_lock;
    cmd && ctl_dio == 8'h11 |=> lockout;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout not set");
  property p_spoll;
    cmd && ctl_dio[7:1] == 7'h0c |=> spoll_mode == !$past(ctl_dio[0]);
  endproperty
  a_spoll: assert property (p_spoll) else $error("poll mode wrong");
  property p_ppu;
    cmd && ctl_dio == 8'h15 |=> !pp_enabled;
  endproperty
  a_ppu: assert property (p_ppu) else $error("poll config kept");
  property p_ign;
    ctl_dav && (atn_n || ren_n) |=> $stable(listener) && $stable(talker);
  endproperty
  a_ign: assert property (p_ign) else $error("non-command byte decoded");
  property p_stat;
    dev_dav |-> dev_dio_oe && dev_dio == status_byte;
  endproperty
  a_stat: assert property (p_stat) else $error("status byte wrong");
  // The device is built without control capability, so control is never taken.
  property p_tct;
    !take_ctl;
  endproperty
  a_tct: assert property (p_tct) else $error("control taken");
  c_trig: cover property (trigger);
  c_stat: cover property (dev_dav);
  c_pp: cover property ($rose(pp_enabled));
endmodule // gpib_link_sva

//--- gpib_pkg.sv
// Types shared by both ends of the instrument bus link.
// Assumes gpib_cfg.svh holds the numeric constants.
package gpib_pkg;
  typedef logic [7:0] bus_byte_t;
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage

//--- tb.sv
// Bench: drives the controller over AXI4-Lite, watches the device end.
// Assumes gpib_if joins the two ends and both share aclk.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] my_addr = '0;
  logic [7:0] status_byte = '0, v = '0;
  logic listener, talker, remote, lockout, spoll_mode, pp_enabled, pp_sense;
  logic [2:0] pp_line, ln = '0;
  logic trigger, dev_clear, take_ctl, probe = 0;
  logic sec_valid;
  logic [7:0] sec_code;
  logic [7:0] qc[$];
  int n_trig = 0, n_clr = 0, n_tct = 0;
  logic l = 0, t = 0, r = 0, k = 0, s = 0, e = 0, sn = 0;
  logic [33:0] qr[$];
  logic [9:0] qs[$];
  int fails = 0, n_checks = 0;
  gpib_if link();
  gpib_controller i_gpib_controller (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus(link));
  gpib_device i_gpib_device (.aclk, .aresetn, .bus(link), .my_addr, .status_byte,
    .listener, .talker, .remote, .lockout, .spoll_mode, .pp_enabled, .pp_sense,
    .pp_line, .trigger, .dev_clear, .take_ctl, .sec_valid, .sec_code);
  gpib_link_sva i_gpib_link_sva (.aclk, .aresetn, .ctl_dio(link.ctl_dio),
    .atn_n(link.atn_n), .ren_n(link.ren_n), .ctl_dav(link.ctl_dav),
    .dev_dio(link.dev_dio), .dev_dio_oe(link.dev_dio_oe), .dev_dav(link.dev_dav),
    .my_addr, .status_byte, .listener, .talker, .remote, .lockout, .spoll_mode,
    .pp_enabled, .trigger, .dev_clear, .take_ctl);
  always #10 aclk = ~aclk;
  // ****************
  // Checking
  // ****************
  task chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hung handshake would stall the queue checks, so every wait is bounded.
  task tick(inout int n);
    n++;
    if (n > 50) begin
      fails++;
      tally_and_finish();
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
    if (probe) chk({listener, talker, remote, lockout, spoll_mode, pp_enabled, pp_sense, pp_line}, qs.pop_front());
    if (sec_valid === 1'b1) chk(sec_code, qc.pop_front());
    // Pulses last one cycle, so they are counted here and judged at the end.
    if (trigger === 1'b1) n_trig++;
    if (dev_clear === 1'b1) n_clr++;
    if (take_ctl === 1'b1) n_tct++;
  end
  // ****************
  // Bus tasks
  // ****************
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      tick(n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [33:0] x);
    int n;
    n = 0;
    qr.push_back(x);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      tick(n);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  // Sends one command byte, then notes the state expected once it has landed.
  task automatic c(input logic [7:0] b);
    wr(12'h004, {24'h00_0001, b});
    repeat (2) @(posedge aclk);
    qs.push_back({l, t, r, k, s, e, sn, ln});
    probe <= 1;
    @(posedge aclk);
    probe <= 0;
  endtask
  initial begin
    void'($urandom(9));
    my_addr <= 5'($urandom_range(30));
    status_byte <= 8'($urandom);
    v = 8'($urandom);
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(12'h000, 34'h0_0000_0001);
    rd(12'h00c, {2'b10, 32'h0000_0000});
    c(8'h01);
    c(8'h04);
    c(8'h05);
    c(8'h08);
    l = 1;
    r = 1;
    c({3'b001, my_addr});
    k = 1;
    c(8'h11);
    r = 0;
    c(8'h01);
    c(8'h08);
    c(8'h04);
    c(8'h05);
    e = 1;
    sn = v[3];
    ln = v[2:0];
    c({4'h6, v[3:0]});
    qc.push_back({4'h6, ~v[3:0]});
    c({4'h6, ~v[3:0]});
    c(8'h05);
    e = 0;
    c(8'h70);
    c(8'h05);
    e = 1;
    c({4'h6, v[3:0]});
    e = 0;
    sn = 0;
    ln = '0;
    c(8'h15);
    l = 0;
    c(8'h3f);
    c(8'h14);
    wr(12'h000, 32'h0000_0000);
    c({3'b001, my_addr});
    wr(12'h000, 32'h0000_0001);
    t = 1;
    r = 1;
    c({3'b010, my_addr});
    t = 0;
    c({3'b010, 5'(my_addr + 5'h01)});
    t = 1;
    c({3'b010, my_addr});
    t = 0;
    c(8'h5f);
    s = 1;
    c(8'h18);
    t = 1;
    c({3'b010, my_addr});
    c(8'h09);
    wr(12'h004, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    rd(12'h008, {2'b00, 24'h00_0001, status_byte});
    s = 0;
    c(8'h19);
    chk(n_trig, 1);
    chk(n_clr, 2);
    chk(n_tct, 0);
    chk(qc.size(), 0);
    tally_and_finish();
  end
endmodule // tb
